// ==== include/mcu_irq_pkg.sv ====
/*
  Constants, vectors, timing counts and state encodings shared by the
  interrupt and reset logic and its pin synchroniser.
  Assumes a 10 MHz E clock and a CPU core that fetches vectors itself.
*/
package mcu_irq_pkg;

  // Slots of the I-maskable group, lowest fixed priority first
  localparam int NUM_IMASK = 15;
  localparam int SRC_SCI = 0;
  localparam int SRC_SPI = 1;
  localparam int SRC_PA_EDGE = 2;
  localparam int SRC_PA_OVF = 3;
  localparam int SRC_TOF = 4;
  localparam int SRC_OC1 = 9;
  localparam int SRC_IC1 = 12;
  localparam int SRC_RTI = 13;
  localparam int SRC_IRQ = 14;

  // Channel counts of the timer
  localparam int NUM_COMPARE = 5;
  localparam int NUM_CAPTURE = 3;

  // Vector pairs; the maskable group sits two bytes apart from the base
  localparam logic [15:0] VEC_IMASK_BASE = 16'hFFD6;
  localparam logic [15:0] VEC_PSEUDO_NMI_PIN = 16'hFFF4;
  localparam logic [15:0] VEC_SWI = 16'hFFF6;
  localparam logic [15:0] VEC_ILLOP = 16'hFFF8;
  localparam logic [15:0] VEC_COP = 16'hFFFA;
  localparam logic [15:0] VEC_CLKMON = 16'hFFFC;
  localparam logic [15:0] VEC_RESET = 16'hFFFE;

  // Counter limits and dividers
  localparam logic [15:0] FREE_MAX = 16'hFFFF;
  localparam logic [3:0] PRESC_MASK_DIV1 = 4'h0;
  localparam logic [3:0] PRESC_MASK_DIV4 = 4'h3;
  localparam logic [3:0] PRESC_MASK_DIV8 = 4'h7;
  localparam logic [3:0] PRESC_MASK_DIV16 = 4'hF;
  localparam logic [15:0] RTI_MASK_EXP13 = 16'h1FFF;
  localparam logic [15:0] RTI_MASK_EXP14 = 16'h3FFF;
  localparam logic [15:0] RTI_MASK_EXP15 = 16'h7FFF;
  localparam logic [15:0] RTI_MASK_EXP16 = 16'hFFFF;
  localparam logic [5:0] PA_DIV_MASK = 6'h3F;
  localparam logic [7:0] PA_MAX = 8'hFF;

  // Capture edge select bits
  localparam int CAP_SEL_RISE_BIT = 0;
  localparam int CAP_SEL_FALL_BIT = 1;

  // Watchdog service keys, arm then fire
  localparam logic [7:0] COP_KEY_ARM = 8'h55;
  localparam logic [7:0] COP_KEY_FIRE = 8'hAA;

  // Timing
  localparam int CLK_PERIOD_NS = 100;
  localparam int RESET_STRETCH_NS = 400;
  localparam int RESET_STRETCH_CYCLES = (RESET_STRETCH_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int CLKMON_MIN_HZ = 200_000;
  localparam int CLKMON_MIN_PERIOD_NS = 1_000_000_000 / CLKMON_MIN_HZ;
  localparam int RESET_PIN_MIN_CYCLES = 8;
  localparam int RESET_PIN_MIN_CYCLES_NOINT = 2;

  // Synchroniser idle levels: {ref, gate, capture[2:0], nmi_n, irq_n, reset_n}
  localparam logic [7:0] PIN_IDLE = 8'h07;

  // Reset sequencer
  typedef enum logic [3:0] {
    RS_POR = 4'b0001,
    RS_PIN = 4'b0010,
    RS_INT = 4'b0100,
    RS_RUN = 4'b1000
  } reset_state_e;

endpackage

// ==== rtl/pin_sync.sv ====
/*
  Two-flop synchroniser for a group of pins with edge detection behind
  the second stage. Assumes the pins are asynchronous to clk.
*/
module pin_sync #(
  parameter int WIDTH = 8,
  parameter logic [WIDTH-1:0] RESET_VAL = '0
) (
  // Clock and reset
  input wire logic clk,
  input wire logic srst,
  // Raw pins
  input wire logic [WIDTH-1:0] pins_async,
  // Synchronised level and edges
  output logic [WIDTH-1:0] level,
  output logic [WIDTH-1:0] rise,
  output logic [WIDTH-1:0] fall
);

  logic [WIDTH-1:0] meta_reg; // First stage, read only by the second
  logic [WIDTH-1:0] sync_reg; // Second stage, safe to use
  logic [WIDTH-1:0] last_reg; // Previous safe value for edges

  // Shift chain
  always_ff @(posedge clk) begin
    if (srst) begin
      meta_reg <= RESET_VAL;
      sync_reg <= RESET_VAL;
      last_reg <= RESET_VAL;
    end else begin
      meta_reg <= pins_async;
      sync_reg <= meta_reg;
      last_reg <= sync_reg;
    end
  end

  assign level = sync_reg;
  assign rise = sync_reg & ~last_reg;
  assign fall = ~sync_reg & last_reg;

endmodule

// ==== rtl/mcu_irq_reset.sv ====
/*
  Interrupt gathering, masking, priority and reset sequencing of an 8-bit
  microcontroller, with the timer, real-time and pulse accumulator event
  sources that feed it. Assumes the CPU core reports instruction ends,
  takes one vector per service_ack and drives its own I bit.
*/
module mcu_irq_reset
  import mcu_irq_pkg::*;
#(
  parameter int POR_DELAY_CYCLES = 4096,
  parameter int COP_TIMEOUT_CYCLES = 65536,
  parameter int CLKMON_REF_HALF_NS = 100_000
) (
  // Clock and power-on reset
  input wire logic clk,
  input wire logic srst,
  // Device pins
  input wire logic reset_pin_n,
  input wire logic irq_pin_n,
  input wire logic pseudo_nmi_pin_n,
  input wire logic [2:0] capture_input_pins,
  input wire logic accumulator_gate_pin,
  input wire logic clkmon_ref_pin,
  // CPU core handshake
  input wire logic i_mask,
  input wire logic x_unmask_req,
  input wire logic instr_done,
  input wire logic service_ack,
  input wire logic swi_exec,
  input wire logic illegal_opcode,
  output logic service_req,
  output logic [15:0] service_vector,
  output logic swi_fetch_allow,
  output logic x_mask,
  output logic cpu_reset,
  output logic [15:0] reset_vector,
  // Configuration bits
  input wire logic [14:0] source_enable,
  input wire logic [3:0] elevate_sel,
  input wire logic [1:0] prescale_sel,
  input wire logic [1:0] rti_rate_sel,
  input wire logic [5:0] capture_edge_sel,
  input wire logic [4:0] compare_pin_enable,
  input wire logic [79:0] compare_words,
  input wire logic pa_enable,
  input wire logic pa_gated_mode,
  input wire logic pa_active_high,
  input wire logic cop_enable_strap,
  input wire logic cop_service_strobe,
  input wire logic [7:0] cop_service_byte,
  input wire logic clkmon_enable,
  // Peripheral events
  input wire logic [3:0] sci_conditions,
  input wire logic [3:0] sci_cond_enable,
  input wire logic spi_done,
  input wire logic parallel_io_event,
  // Flags and timer state
  input wire logic [14:0] flag_clear,
  output logic [14:0] pending_flags,
  output logic [15:0] free_count,
  output logic [47:0] capture_words,
  output logic [4:0] compare_pins,
  output logic [7:0] pa_count
);

  // Clock monitor threshold: cycles a 200 kHz clock gives per ref half period
  localparam logic [15:0] CLKMON_MIN_CYCLES = 16'(CLKMON_REF_HALF_NS / CLKMON_MIN_PERIOD_NS);

  // Synchronised pins
  logic [7:0] pin_level;
  logic [7:0] pin_rise;
  logic [7:0] pin_fall;
  logic rst_pin_low; // Reset pin held low
  logic irq_low; // External maskable request
  logic nmi_low; // Pseudo non-maskable request
  logic gate_level; // Accumulator gate, synchronised

  // Reset sequencing
  reset_state_e rst_state_reg;
  reset_state_e rst_next;
  logic [31:0] rst_cnt_reg; // Cycles spent in the current state
  logic cpu_reset_reg;
  logic [15:0] reset_vector_reg;
  logic dev_rst; // Resets all interrupt and timer state
  logic cop_en_reg; // Watchdog enable caught during reset
  logic cop_armed_reg; // First service key seen
  logic [31:0] cop_cnt_reg;
  logic cop_timeout;
  logic [15:0] cm_cnt_reg; // Cycles since last reference edge
  logic cm_primed_reg; // A first reference edge has been seen
  logic cm_fail_reg;

  // Timer and event sources
  logic [3:0] presc_reg;
  logic [3:0] presc_mask;
  logic presc_tick;
  logic [15:0] free_reg;
  logic count_moved_reg; // Free counter changed last cycle
  logic [15:0] rti_reg;
  logic [15:0] rti_mask;
  logic [5:0] pa_div_reg;
  logic [7:0] pa_cnt_reg;
  logic pa_inc;
  logic pa_edge_hit;
  logic [4:0] compare_pins_reg;
  wire [4:0] oc_hit;
  wire [14:0] set_vec;

  // Interrupt state
  logic [14:0] flag_reg;
  logic [14:0] req_vec;
  logic [14:0] imask_req;
  logic pseudo_nmi_pin_req;
  logic pick_valid;
  logic [3:0] pick_idx;
  logic service_req_reg;
  logic [15:0] service_vector_reg;
  logic x_mask_reg;
  logic swi_block_reg;
  logic swi_fetch_allow_reg;

  // All pins cross into clk before use
  pin_sync #(
    .WIDTH(8),
    .RESET_VAL(PIN_IDLE)
  ) u_pin_sync (
    .clk(clk),
    .srst(srst),
    .pins_async({clkmon_ref_pin, accumulator_gate_pin, capture_input_pins,
                 pseudo_nmi_pin_n, irq_pin_n, reset_pin_n}),
    .level(pin_level),
    .rise(pin_rise),
    .fall(pin_fall)
  );

  assign rst_pin_low = ~pin_level[0];
  assign irq_low = ~pin_level[1];
  assign nmi_low = ~pin_level[2];
  assign gate_level = pin_level[6];
  assign dev_rst = srst | cpu_reset_reg;

  // Reset sequencer next state
  always_comb begin
    rst_next = rst_state_reg;
    case (rst_state_reg)
      RS_POR: begin
        // Pin still low at end of delay keeps us in reset
        if (rst_cnt_reg >= 32'(POR_DELAY_CYCLES - 1)) rst_next = rst_pin_low ? RS_PIN : RS_RUN;
      end
      RS_PIN: begin
        if (!rst_pin_low) rst_next = RS_RUN;
      end
      RS_INT: begin
        if (rst_cnt_reg >= 32'(RESET_STRETCH_CYCLES - 1)) rst_next = rst_pin_low ? RS_PIN : RS_RUN;
      end
      RS_RUN: begin
        // Pin wins; internal sources stretch the reset for a fixed count
        if (rst_pin_low) rst_next = RS_PIN;
        else if (cop_timeout || cm_fail_reg) rst_next = RS_INT;
      end
      default: rst_next = RS_POR;
    endcase
  end

  // Reset sequencer state; only power-on clears it, never a supply drop
  always_ff @(posedge clk) begin
    if (srst) begin
      rst_state_reg <= RS_POR;
      rst_cnt_reg <= '0;
      cpu_reset_reg <= 1'b1;
    end else begin
      rst_state_reg <= rst_next;
      rst_cnt_reg <= (rst_next != rst_state_reg) ? '0 : rst_cnt_reg + 32'd1;
      cpu_reset_reg <= (rst_next != RS_RUN);
    end
  end

  // Vector fetched after reset depends on its cause
  always_ff @(posedge clk) begin
    if (srst) begin
      reset_vector_reg <= VEC_RESET;
    end else if (rst_state_reg == RS_RUN && rst_next == RS_INT) begin
      reset_vector_reg <= cop_timeout ? VEC_COP : VEC_CLKMON;
    end else if (rst_state_reg == RS_RUN && rst_next == RS_PIN) begin
      reset_vector_reg <= VEC_RESET;
    end
  end

  // Watchdog enable is a strap, caught while the core sits in reset
  always_ff @(posedge clk) begin
    if (srst) cop_en_reg <= 1'b0;
    else if (cpu_reset_reg) cop_en_reg <= cop_enable_strap;
  end

  // Watchdog counter with two-key service sequence
  always_ff @(posedge clk) begin
    if (dev_rst) begin
      cop_armed_reg <= 1'b0;
      cop_cnt_reg <= '0;
    end else begin
      if (cop_service_strobe && cop_service_byte == COP_KEY_ARM) cop_armed_reg <= 1'b1;
      else if (cop_service_strobe) cop_armed_reg <= 1'b0;
      // Both keys in order restart the count
      if (cop_service_strobe && cop_service_byte == COP_KEY_FIRE && cop_armed_reg) cop_cnt_reg <= '0;
      else if (cop_en_reg) cop_cnt_reg <= cop_cnt_reg + 32'd1;
    end
  end

  assign cop_timeout = cop_en_reg && (cop_cnt_reg == 32'(COP_TIMEOUT_CYCLES - 1));

  // Clock monitor: too few clk cycles between reference edges means slow clock.
  // A fully stopped clock cannot be seen by logic running on it.
  always_ff @(posedge clk) begin
    if (dev_rst) begin
      cm_cnt_reg <= '0;
      cm_primed_reg <= 1'b0;
      cm_fail_reg <= 1'b0;
    end else if (pin_rise[7] || pin_fall[7]) begin
      cm_cnt_reg <= '0;
      cm_primed_reg <= 1'b1;
      cm_fail_reg <= clkmon_enable && cm_primed_reg && (cm_cnt_reg < CLKMON_MIN_CYCLES);
    end else begin
      if (cm_cnt_reg != 16'hFFFF) cm_cnt_reg <= cm_cnt_reg + 16'h0001;
      cm_fail_reg <= 1'b0;
    end
  end

  // Prescaler tap selection
  always_comb begin
    case (prescale_sel)
      2'h0: presc_mask = PRESC_MASK_DIV1;
      2'h1: presc_mask = PRESC_MASK_DIV4;
      2'h2: presc_mask = PRESC_MASK_DIV8;
      default: presc_mask = PRESC_MASK_DIV16;
    endcase
  end

  assign presc_tick = (presc_reg & presc_mask) == presc_mask;

  // Prescaler and free-running counter, cleared by reset
  always_ff @(posedge clk) begin
    if (dev_rst) begin
      presc_reg <= '0;
      free_reg <= '0;
      count_moved_reg <= 1'b0;
    end else begin
      presc_reg <= presc_reg + 4'h1;
      count_moved_reg <= presc_tick;
      if (presc_tick) free_reg <= free_reg + 16'h0001;
    end
  end

  // Compare against the count each cycle; a hit counts once per count value
  for (genvar c = 0; c < NUM_COMPARE; c++) begin : g_cmp
    assign oc_hit[c] = count_moved_reg && (free_reg == compare_words[16*c +: 16]);
    assign set_vec[SRC_OC1 - c] = oc_hit[c];
  end

  // Compare pins toggle on a hit when enabled
  always_ff @(posedge clk) begin
    if (dev_rst) compare_pins_reg <= '0;
    else compare_pins_reg <= compare_pins_reg ^ (oc_hit & compare_pin_enable);
  end

  // Capture channels latch the count on a selected edge
  for (genvar k = 0; k < NUM_CAPTURE; k++) begin : g_cap
    logic [15:0] cap_reg;
    wire cap_hit;
    assign cap_hit = (capture_edge_sel[2*k + CAP_SEL_RISE_BIT] && pin_rise[3 + k])
                   || (capture_edge_sel[2*k + CAP_SEL_FALL_BIT] && pin_fall[3 + k]);
    // Cleared at reset so the port is never undefined
    always_ff @(posedge clk) begin
      if (dev_rst) cap_reg <= '0;
      else if (cap_hit) cap_reg <= free_reg;
    end
    assign capture_words[16*k +: 16] = cap_reg;
    assign set_vec[SRC_IC1 - k] = cap_hit;
  end

  // Real-time rate selection
  always_comb begin
    case (rti_rate_sel)
      2'h0: rti_mask = RTI_MASK_EXP13;
      2'h1: rti_mask = RTI_MASK_EXP14;
      2'h2: rti_mask = RTI_MASK_EXP15;
      default: rti_mask = RTI_MASK_EXP16;
    endcase
  end

  // Real-time divider runs free of the prescaler
  always_ff @(posedge clk) begin
    if (dev_rst) rti_reg <= '0;
    else rti_reg <= rti_reg + 16'h0001;
  end

  // Pulse accumulator increments: active edges, or E/64 while gate active
  assign pa_inc = pa_enable && (pa_gated_mode
                  ? ((pa_div_reg == PA_DIV_MASK) && (gate_level == pa_active_high))
                  : (pa_active_high ? pin_rise[6] : pin_fall[6]));
  // Gated mode flags the trailing edge, event mode the counted edge
  assign pa_edge_hit = pa_enable && (pa_gated_mode == pa_active_high ? pin_fall[6] : pin_rise[6]);

  // Pulse accumulator divider and counter
  always_ff @(posedge clk) begin
    if (dev_rst) begin
      pa_div_reg <= '0;
      pa_cnt_reg <= '0;
    end else begin
      pa_div_reg <= pa_div_reg + 6'h01;
      if (pa_inc) pa_cnt_reg <= pa_cnt_reg + 8'h01;
    end
  end

  // Event sources into the flag slots
  assign set_vec[SRC_SCI] = |(sci_conditions & sci_cond_enable);
  assign set_vec[SRC_SPI] = spi_done;
  assign set_vec[SRC_PA_EDGE] = pa_edge_hit;
  assign set_vec[SRC_PA_OVF] = pa_inc && (pa_cnt_reg == PA_MAX);
  assign set_vec[SRC_TOF] = presc_tick && (free_reg == FREE_MAX);
  assign set_vec[SRC_RTI] = (rti_reg & rti_mask) == rti_mask;
  assign set_vec[SRC_IRQ] = parallel_io_event;

  // Sticky flags; a set in the clearing cycle wins
  always_ff @(posedge clk) begin
    if (dev_rst) flag_reg <= '0;
    else flag_reg <= (flag_reg & ~flag_clear) | set_vec;
  end

  // Own enables, then the I bit over all fifteen
  always_comb begin
    req_vec = flag_reg & source_enable;
    req_vec[SRC_IRQ] = req_vec[SRC_IRQ] | irq_low; // Pin and parallel I/O share
    imask_req = req_vec & {NUM_IMASK{~i_mask}};
  end

  assign pseudo_nmi_pin_req = nmi_low && !x_mask_reg;

  // Fixed priority, highest slot wins, one slot may be elevated
  always_comb begin
    pick_valid = 1'b0;
    pick_idx = '0;
    for (int i = 0; i < NUM_IMASK; i++) begin
      if (imask_req[i]) begin
        pick_valid = 1'b1;
        pick_idx = 4'(i);
      end
    end
    if (elevate_sel < 4'(NUM_IMASK) && imask_req[elevate_sel]) begin
      pick_valid = 1'b1;
      pick_idx = elevate_sel;
    end
  end

  // Service request to the core, held until acknowledged
  always_ff @(posedge clk) begin
    if (dev_rst) begin
      service_req_reg <= 1'b0;
      service_vector_reg <= VEC_RESET;
    end else if (service_req_reg) begin
      if (service_ack) service_req_reg <= 1'b0;
    end else if (illegal_opcode) begin
      service_req_reg <= 1'b1;
      service_vector_reg <= VEC_ILLOP;
    end else if (swi_exec) begin
      // Trap stacks like any interrupt; the core sets its I bit
      service_req_reg <= 1'b1;
      service_vector_reg <= VEC_SWI;
    end else if (instr_done && !swi_block_reg) begin
      // Only at an instruction boundary
      if (pseudo_nmi_pin_req) begin
        service_req_reg <= 1'b1;
        service_vector_reg <= VEC_PSEUDO_NMI_PIN;
      end else if (pick_valid) begin
        service_req_reg <= 1'b1;
        service_vector_reg <= VEC_IMASK_BASE + {11'h000, pick_idx, 1'b0};
      end
    end
  end

  // X mask: set at reset and on accepting the pin, software can only clear
  always_ff @(posedge clk) begin
    if (dev_rst) x_mask_reg <= 1'b1;
    else if (service_req_reg && service_ack && service_vector_reg == VEC_PSEUDO_NMI_PIN) x_mask_reg <= 1'b1;
    else if (x_unmask_req) x_mask_reg <= 1'b0;
  end

  // After a trap is accepted, no pin or maskable request until one handler instruction ends
  always_ff @(posedge clk) begin
    if (dev_rst) swi_block_reg <= 1'b0;
    else if (service_req_reg && service_ack && service_vector_reg == VEC_SWI) swi_block_reg <= 1'b1;
    else if (instr_done) swi_block_reg <= 1'b0;
  end

  // Trap may be fetched only with nothing unmasked pending
  always_ff @(posedge clk) begin
    if (dev_rst) swi_fetch_allow_reg <= 1'b0;
    else swi_fetch_allow_reg <= !(pseudo_nmi_pin_req || pick_valid || service_req_reg);
  end

  // Outputs straight from flops
  assign service_req = service_req_reg;
  assign service_vector = service_vector_reg;
  assign swi_fetch_allow = swi_fetch_allow_reg;
  assign x_mask = x_mask_reg;
  assign cpu_reset = cpu_reset_reg;
  assign reset_vector = reset_vector_reg;
  assign pending_flags = flag_reg;
  assign free_count = free_reg;
  assign compare_pins = compare_pins_reg;
  assign pa_count = pa_cnt_reg;

endmodule

// ==== verification/irq_checker.sv ====
/* Concurrent checks on the core handshake, masks and resets of mcu_irq_reset.
   Sees only the top ports; bound to every instance of that module. */
module irq_checker
  import mcu_irq_pkg::*;
(
  // Clock and reset
  input wire logic clk,
  input wire logic srst,
  // Core handshake
  input wire logic i_mask,
  input wire logic service_ack,
  input wire logic service_req,
  input wire logic [15:0] service_vector,
  input wire logic x_mask,
  input wire logic cpu_reset,
  input wire logic [15:0] reset_vector,
  // Flags and enables
  input wire logic [14:0] pending_flags,
  input wire logic [14:0] source_enable
);
  timeunit 1ns;
  timeprecision 1ns;
  default clocking @(posedge clk); endclocking
  default disable iff (srst);
  // Some enabled flag is up
  logic armed;
  assign armed = |(pending_flags & source_enable);
  // Grant taken by the core
  sequence grant_s; service_req && service_ack; endsequence
  // New request of the maskable group, IRQ slot excepted
  sequence take_s; $rose(service_req) && service_vector < 16'hFFF2; endsequence
  req_hold_a: assert property (service_req && !service_ack |=> service_req && $stable(service_vector))
    else $error("request dropped before ack");
  ack_drop_a: assert property (grant_s |=> !service_req)
    else $error("request stays after ack");
  xmask_set_a: assert property (grant_s ##0 service_vector == VEC_PSEUDO_NMI_PIN |=> x_mask)
    else $error("pin mask not set on accept");
  xmask_keep_a: assert property (!x_mask && !cpu_reset && !service_ack ##1 !cpu_reset |-> !x_mask)
    else $error("pin mask set again");
  i_gate_a: assert property ($rose(service_req) && service_vector < VEC_PSEUDO_NMI_PIN |-> !$past(i_mask))
    else $error("maskable grant with I set");
  en_gate_a: assert property (take_s |-> $past(armed))
    else $error("grant without enabled flag");
  vec_even_a: assert property (service_req |-> !service_vector[0] && service_vector >= VEC_IMASK_BASE)
    else $error("vector out of table");
  // A grant may still stand in the first cycle of an internal reset
  rst_quiet_a: assert property (cpu_reset && $past(cpu_reset) |-> !service_req && reset_vector[0] == 1'h0)
    else $error("grant while core in reset");
endmodule

bind mcu_irq_reset irq_checker irq_checker_inst (.clk, .srst, .i_mask, .service_ack, .service_req,
  .service_vector, .x_mask, .cpu_reset, .reset_vector, .pending_flags, .source_enable);

// ==== verification/cpu_model.sv ====
/* Behavioural CPU core facing the block.
   Ends an instruction every fourth cycle, acks a grant after ack_delay cycles; drives on falling edges. */
module cpu_model (
  // Clock
  input wire logic clk,
  // Handshake
  input wire logic [1:0] ack_delay,
  input wire logic service_req,
  output logic service_ack = 1'h0,
  output logic instr_done = 1'h0
);
  timeunit 1ns;
  timeprecision 1ns;
  logic [1:0] tick = 2'h0; // Instruction length
  logic [1:0] wait_cnt = 2'h0; // Cycles the grant has stood
  // Spaced instruction ends make grants wait for a boundary
  always @(negedge clk) begin
    tick <= tick + 2'h1;
    instr_done <= (tick == 2'h3);
    if (service_req && !service_ack && wait_cnt == ack_delay) begin
      service_ack <= 1'h1;
      wait_cnt <= 2'h0;
    end else begin
      service_ack <= 1'h0;
      if (service_req && !service_ack) wait_cnt <= wait_cnt + 2'h1;
    end
  end
endmodule

// ==== verification/testbench.sv ====
/* Self-checking bench for mcu_irq_reset with a CPU core model.
   Assumes shortened POR and watchdog counts; inputs change on falling edges. */
module testbench;
  timeunit 1ns;
  timeprecision 1ns;
  import mcu_irq_pkg::*;
  // Design inputs
  logic clk = 0, srst = 1, reset_pin_n = 0, irq_pin_n = 1, pseudo_nmi_pin_n = 1;
  logic accumulator_gate_pin = 0, clkmon_ref_pin = 0, i_mask = 1, x_unmask_req = 0;
  logic swi_exec = 0, illegal_opcode = 0, instr_done, service_ack;
  logic [2:0] capture_input_pins = 0;
  logic [14:0] source_enable = 0, flag_clear = 0;
  logic [3:0] elevate_sel = 4'hF, sci_conditions = 0, sci_cond_enable = 4'hF;
  logic [1:0] prescale_sel = 0, rti_rate_sel = 0;
  logic [5:0] capture_edge_sel = 6'h10; // Channel 3 on rising edge
  logic [4:0] compare_pin_enable = 5'h01;
  logic [79:0] compare_words = {80{1'h1}};
  logic pa_enable = 0, pa_gated_mode = 0, pa_active_high = 1, cop_enable_strap = 0;
  logic cop_service_strobe = 0, clkmon_enable = 0, spi_done = 0, parallel_io_event = 0;
  logic [7:0] cop_service_byte = 0;
  // Design outputs
  logic service_req, swi_fetch_allow, x_mask, cpu_reset;
  logic [15:0] service_vector, reset_vector, free_count;
  logic [14:0] pending_flags;
  logic [47:0] capture_words;
  logic [4:0] compare_pins;
  logic [7:0] pa_count;
  int mismatches = 0, comparisons = 0, cycles = 0;
  logic [15:0] f; // Count seen as a stimulus starts
  // Short counts keep the run brief
  mcu_irq_reset #(.POR_DELAY_CYCLES(16), .COP_TIMEOUT_CYCLES(64), .CLKMON_REF_HALF_NS(20000)) mcu_irq_reset_inst (.*);
  cpu_model cpu_model_inst (.clk(clk), .ack_delay(2'h2), .service_req(service_req),
    .service_ack(service_ack), .instr_done(instr_done));
  // 10 MHz clock
  always #50 clk = ~clk;
  // Compare for vectors
  task automatic check_v(input string what, input logic [15:0] exp, input logic [15:0] got);
    comparisons++;
    if (got !== exp) begin
      mismatches++;
      $display("wrong value %s expected %h seen %h", what, exp, got);
    end
  endtask
  // Compare for single bits
  task automatic check_b(input string what, input logic exp, input logic got);
    check_v(what, {15'h0, exp}, {15'h0, got});
  endtask
  // No grant may appear for n cycles
  task automatic quiet(input int n);
    repeat (n) begin
      @(negedge clk);
      check_b("service_req", 1'h0, service_req);
    end
  endtask
  // Wait for a grant, check it, drop its cause and clear its flag
  task automatic serve(input logic [15:0] exp, input int slot);
    int n;
    n = 0;
    while (service_req !== 1'h1 && n < 300) begin
      @(negedge clk);
      n++;
    end
    check_b("service_req", 1'h1, service_req);
    check_v("service_vector", exp, service_vector);
    // A pending source blocks the trap fetch
    if (exp < VEC_SWI) check_b("swi_fetch_allow", 1'h0, swi_fetch_allow);
    irq_pin_n = 1;
    pseudo_nmi_pin_n = 1;
    sci_conditions = 0;
    if (slot >= 0) flag_clear[slot] = 1'h1;
    @(negedge clk);
    flag_clear = 0;
    repeat (8) @(negedge clk);
  endtask
  // Wait for the core reset level
  task automatic wait_rst(input logic v);
    int n;
    n = 0;
    while (cpu_reset !== v && n < 200) begin
      @(negedge clk);
      n++;
    end
    check_b("cpu_reset", v, cpu_reset);
  endtask
  // Pulse the accumulator pin n times, two cycles per level
  task automatic pulse(input int n);
    repeat (n) begin
      accumulator_gate_pin = 1;
      repeat (2) @(negedge clk);
      accumulator_gate_pin = 0;
      repeat (2) @(negedge clk);
    end
  endtask
  // Verdict and end of run
  task automatic close_out;
    $display("comparisons %0d mismatches %0d", comparisons, mismatches);
    if (mismatches == 0 && comparisons > 0) begin
      $display("Regression OK");
    end else begin
      $display("Regression broken");
    end
    $finish;
  endtask
  // Hang guard, well above the expected run
  always @(posedge clk) begin
    cycles++;
    if (cycles == 20000) begin
      mismatches++;
      close_out();
    end
  end
  // Main sequence
  initial begin
    repeat (6) @(negedge clk);
    check_b("cpu_reset", 1'h1, cpu_reset);
    check_v("reset_vector", VEC_RESET, reset_vector);
    check_b("x_mask", 1'h1, x_mask);
    srst = 0;
    repeat (30) @(negedge clk);
    check_b("cpu_reset", 1'h1, cpu_reset);
    reset_pin_n = 1;
    wait_rst(1'h0);
    $display("test reset done");
    irq_pin_n = 0;
    quiet(12);
    i_mask = 0;
    serve(16'hFFF2, 14);
    spi_done = 1;
    @(negedge clk);
    spi_done = 0;
    quiet(12);
    check_b("pending_spi", 1'h1, pending_flags[1]);
    source_enable = 15'h4003;
    serve(16'hFFD8, 1);
    parallel_io_event = 1;
    @(negedge clk);
    parallel_io_event = 0;
    serve(16'hFFF2, 14);
    for (int k = 0; k < 4; k++) begin
      sci_conditions = 4'h1 << k;
      serve(16'hFFD6, 0);
    end
    // Pin request and serial flag both wait; the elevated low slot must win
    i_mask = 1;
    irq_pin_n = 0;
    sci_conditions = 4'h1;
    elevate_sel = 4'h0;
    quiet(3);
    i_mask = 0;
    serve(16'hFFD6, 0);
    $display("test sources done");
    i_mask = 1;
    pseudo_nmi_pin_n = 0;
    quiet(12);
    check_b("swi_fetch_allow", 1'h1, swi_fetch_allow);
    x_unmask_req = 1;
    @(negedge clk);
    x_unmask_req = 0;
    serve(VEC_PSEUDO_NMI_PIN, -1);
    check_b("x_mask", 1'h1, x_mask);
    swi_exec = 1;
    @(negedge clk);
    swi_exec = 0;
    serve(16'hFFF6, -1);
    illegal_opcode = 1;
    @(negedge clk);
    illegal_opcode = 0;
    serve(16'hFFF8, -1);
    $display("test traps done");
    i_mask = 0;
    source_enable = 15'h0600;
    compare_words[15:0] = free_count + 16'h0028;
    serve(16'hFFE8, 9);
    check_b("compare_pin", 1'h1, compare_pins[0]);
    f = free_count;
    capture_input_pins[2] = 1;
    serve(16'hFFEA, 10);
    // Two sync stages pass before the edge latches the count
    check_v("capture_word", f + 16'h0002, capture_words[47:32]);
    prescale_sel = 2'h1;
    f = free_count;
    repeat (40) @(negedge clk);
    check_v("free_count", f + 16'h000A, free_count);
    $display("test timer done");
    // Event mode: counted rising edges, then the wrap at 256
    source_enable = 15'h0008;
    pa_enable = 1;
    pulse(3);
    check_v("pa_count", 16'h0003, {8'h00, pa_count});
    pulse(253);
    serve(16'hFFDC, 3);
    // Gated mode: only the trailing edge of the gate may request
    pa_gated_mode = 1;
    flag_clear = 15'h0004;
    @(negedge clk);
    flag_clear = 0;
    source_enable = 15'h0004;
    accumulator_gate_pin = 1;
    quiet(8);
    accumulator_gate_pin = 0;
    serve(16'hFFDA, 2);
    $display("test accumulator done");
    cop_enable_strap = 1;
    reset_pin_n = 0;
    repeat (8) @(negedge clk);
    reset_pin_n = 1;
    wait_rst(1'h0);
    wait_rst(1'h1);
    check_v("reset_vector", VEC_COP, reset_vector);
    check_b("x_mask", 1'h1, x_mask);
    // Drop the strap while the core is held so the watchdog stays off
    cop_enable_strap = 0;
    $display("test watchdog done");
    wait_rst(1'h0);
    // Real-time tick lands 2^13 cycles after the core leaves reset
    repeat (8191) @(negedge clk);
    check_b("rti_flag", 1'h0, pending_flags[13]);
    @(negedge clk);
    check_b("rti_flag", 1'h1, pending_flags[13]);
    $display("test real-time done");
    // Reference edges two cycles apart mean a slow clock
    clkmon_enable = 1;
    repeat (3) begin
      clkmon_ref_pin = ~clkmon_ref_pin;
      repeat (2) @(negedge clk);
    end
    wait_rst(1'h1);
    check_v("reset_vector", VEC_CLKMON, reset_vector);
    $display("test monitor done");
    close_out();
  end
endmodule
